// ===== bench/nrs_assertions.sv
`timescale 1ns/1ps
`include "nrs_defs.svh"
module nrs_assertions (
  input wire logic i_clk,          // bench clock
  input wire logic i_rst,          // async reset, active high
  input wire logic host_scl_o,     // controller clock level
  input wire logic host_scl_oe_n,  // controller clock pull
  input wire logic host_sda_o,     // controller data level
  input wire logic host_sda_oe_n,  // controller data pull
  input wire logic dev_sda_o,      // target data level
  input wire logic dev_sda_oe_n,   // target data pull
  input wire logic scl,            // resolved clock line
  input wire logic sda             // resolved data line
);
  logic       scl_q;
  logic       sda_q;
  logic [7:0] hi_cnt;
  logic       start_c;
  logic       stop_c;

  // bus line history and length of the current scl high phase
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      hi_cnt <= 8'h00;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      if (!scl) begin
        hi_cnt <= 8'h00;
      end else if (hi_cnt != 8'hff) begin
        hi_cnt <= hi_cnt + 8'h01;
      end
    end
  end

  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_dev_low_only: assert property (
    (!dev_sda_oe_n && scl) |-> (host_sda_oe_n && !dev_sda_o))
    else $error("target drives data line out of turn");
  chk_sda_stable_hi: assert property ((scl && scl_q) |-> $stable(dev_sda_oe_n))
    else $error("target data moved during clock high");
  chk_change_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("target data edge while clock high");
  chk_drive_holds: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8])
    else $error("target low drive too short");
  chk_ack_sampled: assert property (
    $fell(dev_sda_oe_n) |-> ##[1:140] ($rose(scl) && !dev_sda_oe_n))
    else $error("target low drive not held to clock rise");
  chk_start_listen: assert property (start_c |=> dev_sda_oe_n [*8])
    else $error("target drives right after start");
  chk_stop_idle: assert property (stop_c |=> (dev_sda_oe_n && scl) [*8])
    else $error("bus not idle after stop");
  chk_scl_high_width: assert property (
    $fell(scl) |-> int'(hi_cnt) >= 2 * `NRS_QTR_CYC - 2)
    else $error("clock high phase too short");

  cov_start: cover property (start_c);
  cov_stop: cover property (stop_c);
  cov_target_drive: cover property ($fell(dev_sda_oe_n));
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic       i_clk;
  logic       i_rst;
  logic       go;
  logic       rw;
  logic [6:0] addr;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic       busy;
  logic       done;
  logic       nack;
  logic [7:0] rdata;
  logic [8:0] code;
  logic       range_sel;
  logic       commit;
  logic [7:0] cfg0;
  int         n_mismatch;
  int         compares;
  int         n_commit;
  int         c0;
  logic [7:0] u;
  logic [7:0] l;
  logic [8:0] cur;
  logic [6:0] fa;
  logic [31:0] s;

  nrs_bus_if bus_if ();
  nrs_target nrs_target_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.target),
    .o_neg_rail_voltage_code(code), .o_neg_rail_range_select(range_sel),
    .o_commit(commit), .o_converter_config_0(cfg0));
  nrs_host nrs_host_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if.ctrl), .i_go(go),
    .i_rw(rw), .i_addr(addr), .i_ptr(ptr), .i_wdata(wdata), .o_busy(busy),
    .o_done(done), .o_nack(nack), .o_rdata(rdata));
  nrs_assertions nrs_assertions_inst (.i_clk(i_clk), .i_rst(i_rst),
    .host_scl_o(bus_if.host_scl_o), .host_scl_oe_n(bus_if.host_scl_oe_n),
    .host_sda_o(bus_if.host_sda_o), .host_sda_oe_n(bus_if.host_sda_oe_n),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
    .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (commit === 1'b1) n_commit <= n_commit + 1;
  end

  function automatic logic [8:0] exp_code(input logic [7:0] up, input logic [7:0] lo);
    return {up[0], lo};
  endfunction

  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one whole controller transaction, waits for its done pulse
  task automatic txn(input logic r, input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    go    <= 1'b1;
    rw    <= r;
    addr  <= a;
    ptr   <= p;
    wdata <= d;
    @(posedge i_clk);
    go <= 1'b0;
    @(negedge i_clk);
    cmp("busy while running", 9'h001, {8'h00, busy});
    while (done !== 1'b1 && n < 20000) begin
      @(negedge i_clk);
      n++;
    end
    cmp("busy after done", 9'h000, {8'h00, busy});
    if (n >= 20000) begin
      n_mismatch++;
      close_out();
    end
  endtask

  initial begin
    repeat (90000) @(posedge i_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    i_rst = 1'b1;
    go = 1'b0;
    rw = 1'b0;
    addr = 7'h00;
    ptr = 8'h00;
    wdata = 8'h00;
    n_mismatch = 0;
    compares = 0;
    s = $urandom(32'h953d);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    cmp("code after reset", 9'h000, code);
    cmp("range after reset", 9'h000, {8'h00, range_sel});
    cmp("idle lines", 9'h003, {7'h00, bus_if.scl, bus_if.sda});
    // range bit both ways, other config bits random; converter taken as idle
    for (int b = 1; b >= 0; b--) begin
      u = {7'($urandom()), 1'(b)};
      txn(1'b0, 7'h41, 8'h00, u);
      cmp("range select", {8'h00, 1'(b)}, {8'h00, range_sel});
      cmp("config write", {1'b0, u}, {1'b0, cfg0});
    end
    txn(1'b1, 7'h41, 8'h00, 8'h00);
    cmp("config read", {1'b0, u}, {1'b0, rdata});
    cmp("ack seen", 9'h000, {8'h00, nack});
    cmp("lines after stop", 9'h003, {7'h00, bus_if.scl, bus_if.sda});
    // upper latched, lower commits; first pass maximum code, second zero
    for (int i = 0; i < 3; i++) begin
      u = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      l = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      cur = code;
      c0 = n_commit;
      txn(1'b0, 7'h41, 8'h01, u);
      cmp("code after upper", cur, code);
      cmp("commits after upper", 9'(c0), 9'(n_commit));
      txn(1'b0, 7'h41, 8'h02, l);
      cmp("code after lower", exp_code(u, l), code);
      cmp("commits after lower", 9'(c0 + 1), 9'(n_commit));
      txn(1'b1, 7'h41, 8'h01, 8'h00);
      cmp("upper read", {1'b0, u}, {1'b0, rdata});
    end
    // reset in mid-run clears the setpoint and the range again
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    cmp("code after second reset", 9'h000, code);
    cmp("config after second reset", 9'h000, {1'b0, cfg0});
    // foreign addresses, general call among them, are not answered
    for (int i = 0; i < 3; i++) begin
      cur = code;
      fa = (i == 0) ? 7'h00 : (i == 1) ? 7'h40 : 7'($urandom() % 64);
      txn(1'b0, fa, 8'h02, 8'h5a);
      cmp("foreign nack", 9'h001, {8'h00, nack});
      cmp("foreign code", cur, code);
    end
    close_out();
  end
endmodule

// ===== logic/nrs_bus_if.sv
`timescale 1ns/1ps
interface nrs_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // pulled-up wired-and lines, the target never drives scl
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport target (input scl, sda, output dev_sda_o, dev_sda_oe_n);
  modport ctrl   (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

// ===== logic/nrs_defs.svh
`ifndef NRS_DEFS_SVH
`define NRS_DEFS_SVH

// target address on the two-wire bus, 7 bits
`define NRS_DEV_ADDR       7'h41
// register pointers
`define NRS_PTR_CFG0       8'h00
`define NRS_PTR_UPPER      8'h01
`define NRS_PTR_LOWER      8'h02
// field positions
`define NRS_RANGE_BIT      0
`define NRS_UPPER_CODE_BIT 0
// reset values
`define NRS_CFG0_RST       8'h00
`define NRS_UPPER_RST      8'h00
`define NRS_LOWER_RST      8'h00
`define NRS_CODE_RST       9'h000
// timing
`define NRS_CLK_PERIOD_NS  8
`define NRS_SCL_PERIOD_NS  1000
`define NRS_QTR_CYC        ((`NRS_SCL_PERIOD_NS / 4 + `NRS_CLK_PERIOD_NS - 1) / `NRS_CLK_PERIOD_NS)

`endif

// ===== logic/nrs_host.sv
`timescale 1ns/1ps
`include "nrs_defs.svh"
module nrs_host (
  input  wire logic       i_clk,     // 125 MHz clock
  input  wire logic       i_rst,     // async reset, active high
  nrs_bus_if.ctrl         bus,       // two-wire bus
  input  wire logic       i_go,      // start a transaction
  input  wire logic       i_rw,      // 0 write, 1 read
  input  wire logic [6:0] i_addr,    // target address
  input  wire logic [7:0] i_ptr,     // register pointer
  input  wire logic [7:0] i_wdata,   // write data
  output logic            o_busy,    // transaction running
  output logic            o_done,    // pulse at end
  output logic            o_nack,    // some byte not acknowledged
  output logic [7:0]      o_rdata    // read data
);

  localparam logic [5:0] QTR_LAST = 6'(`NRS_QTR_CYC - 1);

  nrs_pkg::nrs_hst_t s;
  nrs_pkg::nrs_hst_t n;
  logic              tick;

  // quarter scl period enable, bit rate stays at or under 1MHz
  assign tick = (s.div == QTR_LAST);

  always_comb begin
    n      = s;
    n.done = 1'b0;
    n.div  = (tick || s.st == nrs_pkg::HST_IDLE) ? 6'd0 : s.div + 6'd1;
    case (s.st)
      nrs_pkg::HST_IDLE: begin
        if (i_go) begin
          n.st    = nrs_pkg::HST_START;
          n.busy  = 1'b1;
          n.nack  = 1'b0;
          n.rw    = i_rw;
          n.addr  = i_addr;
          n.ptr   = i_ptr;
          n.wdata = i_wdata;
          n.stage = 3'd0;
          n.q     = 2'd0;
        end
      end
      nrs_pkg::HST_START: begin
        if (tick) begin
          n.q = s.q + 2'd1;
          case (s.q)
            2'd0: n.sda_oe_n = 1'b1;
            2'd1: n.scl_oe_n = 1'b1;
            2'd2: n.sda_oe_n = 1'b0;
            default: begin
              n.scl_oe_n = 1'b0;
              n.st       = nrs_pkg::HST_BIT;
              n.cnt      = 4'h0;
              n.sh       = {s.addr, (s.stage == 3'd3)};
            end
          endcase
        end
      end
      nrs_pkg::HST_BIT: begin
        if (tick) begin
          n.q = s.q + 2'd1;
          case (s.q)
            2'd0: n.sda_oe_n = (s.cnt == 4'h8) | (s.stage == 3'd4) | s.sh[7];
            2'd1: n.scl_oe_n = 1'b1;
            2'd2: begin
              if (s.cnt != 4'h8) begin
                n.sh = {s.sh[6:0], bus.sda};
              end else if (s.stage != 3'd4) begin
                n.nack = s.nack | bus.sda;
              end
            end
            default: begin
              n.scl_oe_n = 1'b0;
              n.cnt      = s.cnt + 4'h1;
              if (s.cnt == 4'h8) begin
                n.cnt = 4'h0;
                if (n.nack) begin
                  n.st = nrs_pkg::HST_STOP;
                end else if (s.stage == 3'd0) begin
                  n.stage = 3'd1;
                  n.sh    = s.ptr;
                end else if (s.stage == 3'd1 && s.rw) begin
                  n.stage = 3'd3;
                  n.st    = nrs_pkg::HST_START;
                end else if (s.stage == 3'd1) begin
                  n.stage = 3'd2;
                  n.sh    = s.wdata;
                end else if (s.stage == 3'd3) begin
                  n.stage = 3'd4;
                  n.sh    = 8'hFF;
                end else begin
                  if (s.stage == 3'd4) begin
                    n.rdata = s.sh;
                  end
                  n.st = nrs_pkg::HST_STOP;
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          n.q = s.q + 2'd1;
          case (s.q)
            2'd0: n.sda_oe_n = 1'b0;
            2'd1: n.scl_oe_n = 1'b1;
            2'd2: n.sda_oe_n = 1'b1;
            default: begin
              n.st   = nrs_pkg::HST_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s          <= '0;
      s.st       <= nrs_pkg::HST_IDLE;
      s.scl_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = s.scl_oe_n;
  assign bus.host_sda_oe_n = s.sda_oe_n;
  assign o_busy            = s.busy;
  assign o_done            = s.done;
  assign o_nack            = s.nack;
  assign o_rdata           = s.rdata;

endmodule

// ===== logic/nrs_pkg.sv
package nrs_pkg;

  typedef enum logic [2:0] {TGT_IDLE, TGT_RX, TGT_ACK, TGT_TX, TGT_TXACK} nrs_tgt_st_t;

  typedef struct packed {
    nrs_tgt_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt;
    logic [1:0]  idx;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rd;
    logic        macked;
    logic        sda_oe_n;
    logic [7:0]  cfg0;
    logic [7:0]  upper;
    logic [7:0]  lower;
    logic [8:0]  code;
    logic        commit;
  } nrs_tgt_t;

  typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BIT, HST_STOP} nrs_hst_st_t;

  typedef struct packed {
    nrs_hst_st_t st;
    logic [5:0]  div;
    logic [1:0]  q;
    logic [3:0]  cnt;
    logic [2:0]  stage;
    logic [7:0]  sh;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        busy;
    logic        done;
    logic        nack;
    logic [7:0]  rdata;
    logic        rw;
    logic [6:0]  addr;
    logic [7:0]  ptr;
    logic [7:0]  wdata;
  } nrs_hst_t;

endpackage

// ===== logic/nrs_target.sv
// How it works
// - range bit picks one of two negative spans
// - nine-bit setpoint split over two registers
// - upper byte latched, lower write commits all
// - host changes range only while converter idle
// - device is target only, never clocks
// - seven-bit target address selection
// - works at any bus rate up to 1MHz
// - sda input on receive, open-drain low drive
// - one bit per scl period, stable high
// - sda edge with scl high is control
// - controller starts, clocks and brackets transactions
// - accessed address decides reachable registers
// - start falls, stop rises, idle high
// - msb first, eight bits plus acknowledge
// - write: addr, pointer, data, each acknowledged
`timescale 1ns/1ps
`include "nrs_defs.svh"
module nrs_target (
  input  wire logic       i_clk,                     // 125 MHz clock
  input  wire logic       i_rst,                     // async reset, active high
  nrs_bus_if.target       bus,                       // two-wire bus
  output logic [8:0]      o_neg_rail_voltage_code,   // applied setpoint code
  output logic            o_neg_rail_range_select,   // 0 low span, 1 high span
  output logic            o_commit,                  // pulse on setpoint update
  output logic [7:0]      o_converter_config_0       // config register contents
);

  nrs_pkg::nrs_tgt_t s;
  nrs_pkg::nrs_tgt_t n;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic [7:0]        rdval;
  logic              byte_end;
  logic              addr_hit;
  logic              wr_cfg0;
  logic              wr_upper;
  logic              wr_lower;

  assign scl_rise   = bus.scl & ~s.scl_q;
  assign scl_fall   = ~bus.scl & s.scl_q;
  assign start_cond = bus.scl & s.scl_q & s.sda_q & ~bus.sda;
  assign stop_cond  = bus.scl & s.scl_q & ~s.sda_q & bus.sda;
  // fall that ends the eighth bit, the whole byte sits in the shifter
  assign byte_end   = scl_fall & (s.cnt == 4'h8);
  assign addr_hit   = (s.sh[7:1] == `NRS_DEV_ADDR);

  // read mux, unknown pointers read zero
  always_comb begin
    if (s.ptr == `NRS_PTR_CFG0) begin
      rdval = s.cfg0;
    end else if (s.ptr == `NRS_PTR_UPPER) begin
      rdval = s.upper;
    end else if (s.ptr == `NRS_PTR_LOWER) begin
      rdval = s.lower;
    end else begin
      rdval = 8'h00;
    end
  end

  // write strobes for the data byte that ends now, unknown pointers write nothing
  always_comb begin
    wr_cfg0  = 1'b0;
    wr_upper = 1'b0;
    wr_lower = 1'b0;
    if (s.ptr == `NRS_PTR_CFG0) begin
      wr_cfg0 = 1'b1;
    end else if (s.ptr == `NRS_PTR_UPPER) begin
      wr_upper = 1'b1;
    end else if (s.ptr == `NRS_PTR_LOWER) begin
      wr_lower = 1'b1;
    end
  end

  always_comb begin
    n        = s;
    n.scl_q  = bus.scl;
    n.sda_q  = bus.sda;
    n.commit = 1'b0;
    if (start_cond) begin
      n.st       = nrs_pkg::TGT_RX;
      n.cnt      = 4'h0;
      n.idx      = 2'd0;
      n.rd       = 1'b0;
      n.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      n.st       = nrs_pkg::TGT_IDLE;
      n.sda_oe_n = 1'b1;
    end else begin
      case (s.st)
        nrs_pkg::TGT_RX: begin
          if (scl_rise) begin
            n.sh  = {s.sh[6:0], bus.sda};
            n.cnt = s.cnt + 4'h1;
          end
          if (byte_end) begin
            n.cnt = 4'h0;
            if (s.idx == 2'h0) begin
              // a foreign address leaves the target deaf until the next start
              if (addr_hit) begin
                n.rd       = s.sh[0];
                n.st       = nrs_pkg::TGT_ACK;
                n.sda_oe_n = 1'b0;
              end else begin
                n.st = nrs_pkg::TGT_IDLE;
              end
              n.idx = 2'h1;
            end else begin
              n.st       = nrs_pkg::TGT_ACK;
              n.sda_oe_n = 1'b0;
              if (s.idx == 2'h1) begin
                n.ptr = s.sh;
                n.idx = 2'h2;
              end else begin
                n.ptr = s.ptr + 8'h01;
                if (wr_cfg0) begin
                  n.cfg0 = s.sh;
                end
                if (wr_upper) begin
                  n.upper = s.sh;
                end
                // apart from reset, the only place the applied code moves, all nine bits at once
                if (wr_lower) begin
                  n.lower  = s.sh;
                  n.code   = {s.upper[`NRS_UPPER_CODE_BIT], s.sh};
                  n.commit = 1'b1;
                end
              end
            end
          end
        end
        // ack is held from the byte's last fall to the fall of the ack clock
        nrs_pkg::TGT_ACK: begin
          if (scl_fall) begin
            if (s.rd) begin
              n.sh       = rdval;
              n.ptr      = s.ptr + 8'h01;
              n.cnt      = 4'h0;
              n.st       = nrs_pkg::TGT_TX;
              n.sda_oe_n = rdval[7];
            end else begin
              n.st       = nrs_pkg::TGT_RX;
              n.sda_oe_n = 1'b1;
            end
          end
        end
        // a bit changes only after a fall, so it stands through the high phase
        nrs_pkg::TGT_TX: begin
          if (scl_fall) begin
            if (s.cnt == 4'h7) begin
              n.st       = nrs_pkg::TGT_TXACK;
              n.sda_oe_n = 1'b1;
            end else begin
              n.sh       = {s.sh[6:0], 1'b0};
              n.sda_oe_n = s.sh[6];
              n.cnt      = s.cnt + 4'h1;
            end
          end
        end
        // controller ack keeps the read streaming, a nack ends it
        nrs_pkg::TGT_TXACK: begin
          if (scl_rise) begin
            n.macked = ~bus.sda;
          end
          if (scl_fall) begin
            if (s.macked) begin
              n.sh       = rdval;
              n.ptr      = s.ptr + 8'h01;
              n.cnt      = 4'h0;
              n.st       = nrs_pkg::TGT_TX;
              n.sda_oe_n = rdval[7];
            end else begin
              n.st = nrs_pkg::TGT_IDLE;
            end
          end
        end
        default: begin
          n.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // line history resets high so the idle bus after reset shows no false start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s          <= '0;
      s.st       <= nrs_pkg::TGT_IDLE;
      s.scl_q    <= 1'b1;
      s.sda_q    <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.cfg0     <= `NRS_CFG0_RST;
      s.upper    <= `NRS_UPPER_RST;
      s.lower    <= `NRS_LOWER_RST;
      s.code     <= `NRS_CODE_RST;
    end else begin
      s <= n;
    end
  end

  assign bus.dev_sda_o            = 1'b0;
  assign bus.dev_sda_oe_n         = s.sda_oe_n;
  assign o_neg_rail_voltage_code  = s.code;
  assign o_neg_rail_range_select  = s.cfg0[`NRS_RANGE_BIT];
  assign o_commit                 = s.commit;
  assign o_converter_config_0     = s.cfg0;

endmodule
